/* File: hw/rbd_pkg.sv */
// Constants, types and register map of the receive buffer descriptor manager
package rbd_pkg;

  // --------------------------------------------------------------------------
  // Register map (byte offsets)
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RX_CONTROL = 8'h08;
  localparam logic [7:0] REG_CUR_BUF_ADDR = 8'h0C;
  localparam logic [7:0] REG_REM_WORDS = 8'h10;
  localparam logic [7:0] REG_EOB_THRESHOLD = 8'h14;
  localparam logic [7:0] REG_SEQUENCE = 8'h18;
  localparam logic [7:0] REG_CUR_DESC_ADDR = 8'h1C;
  localparam logic [7:0] REG_UPPER_DESC = 8'h20;
  localparam logic [7:0] REG_UPPER_RES = 8'h24;
  localparam logic [7:0] REG_RES_START = 8'h28;
  localparam logic [7:0] REG_RES_END = 8'h2C;
  localparam logic [7:0] REG_RES_READ = 8'h30;
  localparam logic [7:0] REG_RES_WRITE = 8'h34;

  // --------------------------------------------------------------------------
  // Bit positions and reset values
  // --------------------------------------------------------------------------
  localparam int CMD_READ_RES = 0;
  localparam int CMD_RX_ENABLE = 1;
  localparam int CMD_MODE32 = 2;
  localparam int ST_BUF_EXCEEDED = 0;
  localparam int ST_DESC_EXHAUSTED = 1;
  localparam int ST_RES_EXHAUSTED = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_EOL = 4;
  localparam int LAST_PACKET_IN_BUFFER_BIT = 6;
  localparam logic [15:0] EOB_RESET = 16'h02F8;
  localparam logic [15:0] RX_CTRL_RESET = 16'h0000;

  // --------------------------------------------------------------------------
  // Descriptor field indices and strides
  // --------------------------------------------------------------------------
  localparam logic [2:0] FLD_STATUS = 3'h0;
  localparam logic [2:0] FLD_SEQ = 3'h4;
  localparam logic [2:0] FLD_LINK = 3'h5;
  localparam logic [2:0] FLD_INUSE = 3'h6;
  localparam logic [2:0] FLD_RES_LAST = 3'h3;
  localparam logic [15:0] RES_STEP16 = 16'h0008;
  localparam logic [15:0] RES_STEP32 = 16'h0010;
  localparam logic [31:0] BYTES16 = 32'h0000_0002;
  localparam logic [31:0] BYTES32 = 32'h0000_0004;
  localparam logic [31:0] WORDS16 = 32'h0000_0001;
  localparam logic [31:0] WORDS32 = 32'h0000_0002;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rbd_mem_req_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } rbd_rx_beat_type;

  typedef struct packed {
    logic [15:0] byte_count;
    logic [7:0] flags;
    logic multicast;
  } rbd_rx_end_type;

endpackage

/* File: hw/rbd_manager.sv */
// Receive buffer and descriptor manager with Avalon-MM register slave and memory master
`timescale 1ns/1ps
module rbd_manager (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rx_start_i,
  input wire rbd_pkg::rbd_rx_beat_type rx_beat_i,
  input wire rbd_pkg::rbd_rx_end_type rx_end_i,
  output logic rx_ready_o,
  output rbd_pkg::rbd_mem_req_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);

  typedef enum logic [3:0] {
    S_IDLE, S_RES_RD, S_REREAD, S_RECV, S_DROP, S_DESC_WR, S_LINK_RD, S_INUSE_WR, S_RELEASE_WR, S_END_CHK
  } rbd_state_type;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [31:0] fld_addr(input logic [15:0] upper, input logic [15:0] base,
                                            input logic [2:0] idx, input logic m32);
    logic [15:0] off;
    off = m32 ? {11'h000, idx, 2'b00} : {12'h000, idx, 1'b0};
    fld_addr = {upper, 16'(base + off)};
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    be_merge = res;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rbd_state_type state;
  logic [2:0] idx;
  logic [2:0] command;
  logic [4:0] flags;
  logic [15:0] rx_control;
  logic [31:0] cur_buf_addr;
  logic [31:0] rem_words;
  logic [15:0] eob_threshold;
  logic [7:0] buf_seq;
  logic [7:0] pkt_seq;
  logic [15:0] cur_desc;
  logic [15:0] prev_desc;
  logic [15:0] release_desc;
  logic release_pend;
  logic end_of_list_flag;
  logic [15:0] upper_desc;
  logic [15:0] upper_res;
  logic [15:0] res_start;
  logic [15:0] res_end;
  logic [15:0] res_read;
  logic [15:0] res_write;
  logic [31:0] pkt_addr;
  logic [31:0] res_ptr;
  logic [15:0] res_wc0;
  logic auto_fetch;
  logic last_seen;
  logic overrun;
  rbd_pkg::rbd_rx_end_type end_info;
  logic bus_ack;

  logic m32;
  logic [31:0] step_bytes;
  logic [31:0] step_words;
  logic [15:0] thr_eff;
  logic below_thr;
  logic bus_wr;
  logic [31:0] rd_mux;
  logic [15:0] next_res_read;
  logic beat_take;
  logic mem_q_req;
  logic mem_q_we;
  logic [31:0] mem_q_addr;
  logic [31:0] mem_q_wdata;

  assign m32 = command[rbd_pkg::CMD_MODE32];
  assign step_bytes = m32 ? rbd_pkg::BYTES32 : rbd_pkg::BYTES16;
  assign step_words = m32 ? rbd_pkg::WORDS32 : rbd_pkg::WORDS16;
  // LSB held low in 32-bit mode so the compare matches even word counts
  assign thr_eff = m32 ? {eob_threshold[15:1], 1'b0} : eob_threshold;
  assign below_thr = rem_words < {16'h0000, thr_eff};
  assign next_res_read = 16'(res_read + (m32 ? rbd_pkg::RES_STEP32 : rbd_pkg::RES_STEP16));
  assign beat_take = rx_beat_i.valid && rx_ready_o;
  // Data is accepted only when no write is outstanding, so the MAC stalls on slow memory
  assign rx_ready_o = (state == S_DROP) || (state == S_RECV && !mem_o.req && !last_seen);
  assign mem_o.req = mem_q_req;
  assign mem_o.we = mem_q_we;
  assign mem_o.addr = mem_q_addr;
  assign mem_o.wdata = mem_q_wdata;

  // --------------------------------------------------------------------------
  // Avalon-MM slave: one wait state, read data from a flip-flop
  // --------------------------------------------------------------------------
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !bus_ack;
  assign bus_wr = avs_write_i && bus_ack;

  always_comb
  begin
    case (avs_address_i)
      rbd_pkg::REG_COMMAND: rd_mux = {29'h0, command};
      rbd_pkg::REG_STATUS: rd_mux = {27'h0, end_of_list_flag, state != S_IDLE, flags[2:0]};
      rbd_pkg::REG_RX_CONTROL: rd_mux = {16'h0, rx_control};
      rbd_pkg::REG_CUR_BUF_ADDR: rd_mux = cur_buf_addr;
      rbd_pkg::REG_REM_WORDS: rd_mux = rem_words;
      rbd_pkg::REG_EOB_THRESHOLD: rd_mux = {16'h0, eob_threshold};
      rbd_pkg::REG_SEQUENCE: rd_mux = {16'h0, buf_seq, pkt_seq};
      rbd_pkg::REG_CUR_DESC_ADDR: rd_mux = {16'h0, cur_desc};
      rbd_pkg::REG_UPPER_DESC: rd_mux = {16'h0, upper_desc};
      rbd_pkg::REG_UPPER_RES: rd_mux = {16'h0, upper_res};
      rbd_pkg::REG_RES_START: rd_mux = {16'h0, res_start};
      rbd_pkg::REG_RES_END: rd_mux = {16'h0, res_end};
      rbd_pkg::REG_RES_READ: rd_mux = {16'h0, res_read};
      rbd_pkg::REG_RES_WRITE: rd_mux = {16'h0, res_write};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bus_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      bus_ack <= (avs_read_i || avs_write_i) && !bus_ack;
      if (avs_read_i && !bus_ack)
        avs_readdata_o <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // Software-only configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_control <= rbd_pkg::RX_CTRL_RESET;
      eob_threshold <= rbd_pkg::EOB_RESET;
      upper_desc <= 16'h0000;
      upper_res <= 16'h0000;
      res_start <= 16'h0000;
      res_end <= 16'h0000;
      res_write <= 16'h0000;
    end
    else if (bus_wr)
    begin
      case (avs_address_i)
        rbd_pkg::REG_RX_CONTROL: rx_control <= 16'(be_merge({16'h0, rx_control}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_EOB_THRESHOLD:
          eob_threshold <= 16'(be_merge({16'h0, eob_threshold}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_UPPER_DESC: upper_desc <= 16'(be_merge({16'h0, upper_desc}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_UPPER_RES: upper_res <= 16'(be_merge({16'h0, upper_res}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_RES_START: res_start <= 16'(be_merge({16'h0, res_start}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_RES_END: res_end <= 16'(be_merge({16'h0, res_end}, avs_writedata_i, avs_byteenable_i));
        rbd_pkg::REG_RES_WRITE: res_write <= 16'(be_merge({16'h0, res_write}, avs_writedata_i, avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sticky status flags: hardware set wins over a write-one clear
  // --------------------------------------------------------------------------
  logic [2:0] flag_set;

  always_comb
  begin
    flag_set = 3'b000;
    if (state == S_RECV && beat_take && rem_words < step_words)
      flag_set[rbd_pkg::ST_BUF_EXCEEDED] = 1'b1;
    if (state == S_LINK_RD && mem_ack_i && mem_rdata_i[0])
      flag_set[rbd_pkg::ST_DESC_EXHAUSTED] = 1'b1;
    if (state == S_RES_RD && mem_ack_i && idx == rbd_pkg::FLD_RES_LAST
        && res_write == ((next_res_read == res_end) ? res_start : next_res_read))
      flag_set[rbd_pkg::ST_RES_EXHAUSTED] = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flags <= 5'h00;
    else
    begin
      if (bus_wr && avs_address_i == rbd_pkg::REG_STATUS && avs_byteenable_i[0])
        flags <= {2'b00, (flags[2:0] & ~avs_writedata_i[2:0]) | flag_set};
      else
        flags <= {2'b00, flags[2:0] | flag_set};
    end
  end

  // --------------------------------------------------------------------------
  // Receive engine and engine-owned registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= S_IDLE;
      idx <= 3'h0;
      command <= 3'h0;
      cur_buf_addr <= 32'h0000_0000;
      rem_words <= 32'h0000_0000;
      buf_seq <= 8'h00;
      pkt_seq <= 8'h00;
      cur_desc <= 16'h0000;
      prev_desc <= 16'h0000;
      release_desc <= 16'h0000;
      release_pend <= 1'b0;
      end_of_list_flag <= 1'b0;
      res_read <= 16'h0000;
      pkt_addr <= 32'h0000_0000;
      res_ptr <= 32'h0000_0000;
      res_wc0 <= 16'h0000;
      auto_fetch <= 1'b0;
      last_seen <= 1'b0;
      overrun <= 1'b0;
      end_info <= '0;
      mem_q_req <= 1'b0;
      mem_q_we <= 1'b0;
      mem_q_addr <= 32'h0000_0000;
      mem_q_wdata <= 32'h0000_0000;
    end
    else
    begin
      if (bus_wr)
      begin
        case (avs_address_i)
          rbd_pkg::REG_COMMAND: command <= 3'(be_merge({29'h0, command}, avs_writedata_i, avs_byteenable_i));
          rbd_pkg::REG_CUR_BUF_ADDR: cur_buf_addr <= be_merge(cur_buf_addr, avs_writedata_i, avs_byteenable_i);
          rbd_pkg::REG_REM_WORDS: rem_words <= be_merge(rem_words, avs_writedata_i, avs_byteenable_i);
          rbd_pkg::REG_SEQUENCE:
          begin
            buf_seq <= avs_byteenable_i[1] ? avs_writedata_i[15:8] : buf_seq;
            pkt_seq <= avs_byteenable_i[0] ? avs_writedata_i[7:0] : pkt_seq;
          end
          rbd_pkg::REG_CUR_DESC_ADDR:
          begin
            cur_desc <= 16'(be_merge({16'h0, cur_desc}, avs_writedata_i, avs_byteenable_i));
            end_of_list_flag <= 1'b0;
          end
          rbd_pkg::REG_RES_READ: res_read <= 16'(be_merge({16'h0, res_read}, avs_writedata_i, avs_byteenable_i));
          default: ;
        endcase
      end
      if (mem_q_req && mem_ack_i)
        mem_q_req <= 1'b0;
      case (state)
        S_IDLE:
        begin
          idx <= 3'h0;
          if (command[rbd_pkg::CMD_READ_RES])
          begin
            auto_fetch <= 1'b0;
            state <= S_RES_RD;
          end
          else if (rx_start_i && command[rbd_pkg::CMD_RX_ENABLE])
          begin
            pkt_addr <= cur_buf_addr;
            last_seen <= 1'b0;
            overrun <= 1'b0;
            state <= end_of_list_flag ? S_REREAD : S_RECV;
          end
        end
        S_RES_RD:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b0;
            mem_q_addr <= fld_addr(upper_res, res_read, idx, m32);
          end
          else if (mem_ack_i)
          begin
            idx <= 3'(idx + 3'h1);
            case (idx)
              3'h0: res_ptr[15:0] <= mem_rdata_i[15:0];
              3'h1: res_ptr[31:16] <= mem_rdata_i[15:0];
              3'h2: res_wc0 <= mem_rdata_i[15:0];
              default:
              begin
                cur_buf_addr <= res_ptr;
                rem_words <= {mem_rdata_i[15:0], res_wc0};
                res_read <= (next_res_read == res_end) ? res_start : next_res_read;
                if (auto_fetch)
                begin
                  buf_seq <= 8'(buf_seq + 8'h01);
                  pkt_seq <= 8'h00;
                end
                else
                  command[rbd_pkg::CMD_READ_RES] <= 1'b0;
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_REREAD:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b0;
            mem_q_addr <= fld_addr(upper_desc, cur_desc, rbd_pkg::FLD_LINK, m32);
          end
          else if (mem_ack_i)
          begin
            if (mem_rdata_i[0])
              state <= S_DROP;
            else
            begin
              release_pend <= 1'b1;
              release_desc <= cur_desc;
              cur_desc <= {mem_rdata_i[15:1], 1'b0};
              end_of_list_flag <= 1'b0;
              state <= S_RECV;
            end
          end
        end
        S_RECV:
        begin
          if (beat_take)
          begin
            if (rx_beat_i.last)
            begin
              last_seen <= 1'b1;
              end_info <= rx_end_i;
            end
            // Overrun halts writes so nothing lands past the buffer end
            if (overrun || rem_words < step_words)
              overrun <= 1'b1;
            else
            begin
              mem_q_req <= 1'b1;
              mem_q_we <= 1'b1;
              mem_q_addr <= cur_buf_addr;
              mem_q_wdata <= m32 ? rx_beat_i.data : {16'h0000, rx_beat_i.data[15:0]};
            end
          end
          if (mem_q_req && mem_ack_i)
          begin
            cur_buf_addr <= cur_buf_addr + step_bytes;
            rem_words <= rem_words - step_words;
          end
          if (last_seen && !mem_q_req)
          begin
            idx <= rbd_pkg::FLD_STATUS;
            state <= S_DESC_WR;
          end
        end
        S_DROP:
        begin
          if (beat_take && rx_beat_i.last)
            state <= S_IDLE;
        end
        S_DESC_WR:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b1;
            mem_q_addr <= fld_addr(upper_desc, cur_desc, idx, m32);
            case (idx)
              3'h0: mem_q_wdata <= {16'h0000, rx_control[15:9], end_info.multicast, end_info.flags[7],
                                    below_thr, end_info.flags[5:0]};
              3'h1: mem_q_wdata <= {16'h0000, end_info.byte_count};
              3'h2: mem_q_wdata <= {16'h0000, pkt_addr[15:0]};
              3'h3: mem_q_wdata <= {16'h0000, pkt_addr[31:16]};
              default: mem_q_wdata <= {16'h0000, buf_seq, pkt_seq};
            endcase
          end
          else if (mem_ack_i)
          begin
            idx <= 3'(idx + 3'h1);
            if (idx == rbd_pkg::FLD_SEQ)
              state <= S_LINK_RD;
          end
        end
        S_LINK_RD:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b0;
            mem_q_addr <= fld_addr(upper_desc, cur_desc, rbd_pkg::FLD_LINK, m32);
          end
          else if (mem_ack_i)
          begin
            if (mem_rdata_i[0])
            begin
              end_of_list_flag <= 1'b1;
              state <= release_pend ? S_RELEASE_WR : S_END_CHK;
            end
            else
            begin
              prev_desc <= cur_desc;
              cur_desc <= {mem_rdata_i[15:1], 1'b0};
              state <= S_INUSE_WR;
            end
          end
        end
        S_INUSE_WR:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b1;
            mem_q_addr <= fld_addr(upper_desc, prev_desc, rbd_pkg::FLD_INUSE, m32);
            mem_q_wdata <= 32'h0000_0000;
          end
          else if (mem_ack_i)
            state <= release_pend ? S_RELEASE_WR : S_END_CHK;
        end
        S_RELEASE_WR:
        begin
          if (!mem_q_req)
          begin
            mem_q_req <= 1'b1;
            mem_q_we <= 1'b1;
            mem_q_addr <= fld_addr(upper_desc, release_desc, rbd_pkg::FLD_INUSE, m32);
            mem_q_wdata <= 32'h0000_0000;
          end
          else if (mem_ack_i)
          begin
            release_pend <= 1'b0;
            state <= S_END_CHK;
          end
        end
        S_END_CHK:
        begin
          idx <= 3'h0;
          if (below_thr)
          begin
            auto_fetch <= 1'b1;
            state <= S_RES_RD;
          end
          else
          begin
            pkt_seq <= 8'(pkt_seq + 8'h01);
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: verification/rbd_manager_props.sv */
// Port checker for the receive buffer descriptor manager
`timescale 1ns/1ps
module rbd_manager_props (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire rbd_pkg::rbd_rx_beat_type rx_beat_i,
  input wire logic rx_ready_o,
  input wire rbd_pkg::rbd_mem_req_type mem_o,
  input wire logic mem_ack_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  a_req_hold: assert property (mem_o.req && !mem_ack_i |=> $stable(mem_o)) else $error("req moved");
  a_req_gap: assert property (mem_o.req && mem_ack_i |=> !mem_o.req) else $error("no gap");
  a_addr_even: assert property (mem_o.req |-> !mem_o.addr[0]) else $error("odd address");
  a_ready_wr: assert property (mem_o.req && mem_o.we |-> !rx_ready_o) else $error("ready in write");
  a_beat_write: assert property (rx_beat_i.valid && rx_ready_o |=> ##[0:1] (mem_o.req || rx_ready_o))
    else $error("beat not written");
  a_bus_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus wait");
  a_bus_idle: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o) else $error("idle wait");
  a_rdata_hold: assert property (!avs_read_i ##1 !avs_read_i |-> $stable(avs_readdata_o))
    else $error("readdata moved");
endmodule
bind rbd_manager rbd_manager_props i_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rx_beat_i(rx_beat_i), .rx_ready_o(rx_ready_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i));

/* File: verification/rbd_mem_model.sv */
// Behavioural system memory on the manager's master port
`timescale 1ns/1ps
module rbd_mem_model (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire rbd_pkg::rbd_mem_req_type mem_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [15:0] mem [logic [31:0]];
  int dly;
  // Random latency: answers come both promptly and slowly
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_o <= 1'b0;
      dly <= 0;
      rdata_o <= 32'hFFFF_FFFF;
    end
    else if (ack_o || !mem_i.req)
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // Released data is inverted each cycle, showing the last value every other cycle
    end
    else if (dly != 0)
      dly <= dly - 1;
    else
    begin
      ack_o <= 1'b1;
      dly <= $urandom_range(3);
      rdata_o <= {16'hFFFF, mem.exists(mem_i.addr) ? mem[mem_i.addr] : 16'hFFFF};
      if (mem_i.we)
        mem[mem_i.addr] = mem_i.wdata[15:0];
    end
  end
endmodule

/* File: verification/rbd_manager_tb.sv */
// Self-checking bench for the receive buffer descriptor manager
`timescale 1ns/1ps
module rbd_manager_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic start = 1'b0;
  rbd_pkg::rbd_rx_beat_type beat = '0;
  rbd_pkg::rbd_rx_end_type fin = '0;
  logic [31:0] rdata, mrd, q, r;
  logic wait_o, ready, ack;
  rbd_pkg::rbd_mem_req_type mreq;
  int num_errors = 0;
  int n_tests = 0;
  logic [15:0] ctl;
  logic [15:0] dat [2];
  logic [7:0] ra [10] = '{8'h08, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h1C, 8'h00};
  logic [15:0] rv [10] = '{16'h0, 16'h4, 16'h1, 16'h2, 16'h100, 16'h110, 16'h100, 16'h110, 16'h400, 16'h3};
  logic [15:0] res [8] = '{16'h2000, 16'h0, 16'h6, 16'h0, 16'h3000, 16'h0, 16'h10, 16'h0};
  always #50 mclk_i = ~mclk_i;
  rbd_manager i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .rx_start_i(start), .rx_beat_i(beat), .rx_end_i(fin), .rx_ready_o(ready),
    .mem_o(mreq), .mem_ack_i(ack), .mem_rdata_i(mrd));
  rbd_mem_model i_mem (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .mem_i(mreq), .ack_o(ack), .rdata_o(mrd));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge mclk_i); while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  task automatic mchk(input string n, input logic [31:0] a, input logic [15:0] e);
    chk(n, {16'h0, i_mem.mem[a]}, {16'h0, e});
  endtask
  // Expected status word: config and multicast high, MAC flags low, last-packet from the threshold
  function automatic logic [15:0] status_exp(input logic last_packet_in_buffer);
    status_exp = {ctl[15:9], r[0], r[8], last_packet_in_buffer, r[6:1]};
  endfunction
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      k++;
    end
    while (q[b] !== 1'b0 && k < 100);
    chk("idle", {31'h0, q[b]}, 32'h0);
  endtask
  task automatic pkt(input int n);
    r = $urandom;
    start <= 1'b1;
    fin <= r[24:0];
    @(posedge mclk_i);
    start <= 1'b0;
    for (int k = 0; k < n; k++)
    begin
      dat[k] = 16'($urandom);
      beat <= '{1'b1, k == n - 1, {16'h0, dat[k]}};
      do @(posedge mclk_i); while (ready !== 1'b1);
    end
    beat <= '0;
    poll(rbd_pkg::REG_STATUS, 3);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #2_000_000; // Some 20000 cycles, far past the few hundred the sequence needs
    num_errors++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h5e6b));
    ctl = 16'($urandom);
    rv[0] = ctl;
    foreach (res[i]) i_mem.mem[32'h0002_0100 + 2 * i] = res[i];
    i_mem.mem[32'h0001_040A] = 16'h0410;
    i_mem.mem[32'h0001_041A] = 16'h0421;
    i_mem.mem[32'h0001_040C] = 16'h00AA;
    i_mem.mem[32'h0001_041C] = 16'h00AA;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rchk("threshold", rbd_pkg::REG_EOB_THRESHOLD, 32'h2F8);
    bus(1'b1, rbd_pkg::REG_SEQUENCE, 32'h0);
    rchk("seq", rbd_pkg::REG_SEQUENCE, 32'h0);
    foreach (ra[i]) bus(1'b1, ra[i], {16'h0, rv[i]});
    poll(rbd_pkg::REG_COMMAND, 0);
    rchk("buffer", rbd_pkg::REG_CUR_BUF_ADDR, 32'h2000);
    rchk("rdptr", rbd_pkg::REG_RES_READ, 32'h108);
    rchk("seq", rbd_pkg::REG_SEQUENCE, 32'h0);
    pkt(2);
    mchk("data1", 32'h2002, dat[1]);
    rchk("words", rbd_pkg::REG_REM_WORDS, 32'h4);
    mchk("status", 32'h1_0400, status_exp(1'b0));
    mchk("count", 32'h1_0402, r[24:9]);
    mchk("pointer", 32'h1_0404, 16'h2000);
    mchk("inuse", 32'h1_040C, 16'h0);
    rchk("desc", rbd_pkg::REG_CUR_DESC_ADDR, 32'h410);
    pkt(1);
    mchk("data2", 32'h2004, dat[0]);
    mchk("status", 32'h1_0410, status_exp(1'b1));
    mchk("seqfld", 32'h1_0418, 16'h0001);
    mchk("inuse", 32'h1_041C, 16'h00AA);
    rchk("buffer", rbd_pkg::REG_CUR_BUF_ADDR, 32'h3000);
    rchk("seq", rbd_pkg::REG_SEQUENCE, 32'h0100);
    rchk("rdptr", rbd_pkg::REG_RES_READ, 32'h100);
    rchk("unmapped", 8'h3C, 32'h0);
    // Software appends a descriptor behind the held one; the next packet re-reads the link
    i_mem.mem[32'h0001_041A] = 16'h0430;
    pkt(1);
    mchk("status", 32'h1_0430, status_exp(1'b0));
    mchk("data3", 32'h3000, dat[0]);
    mchk("seqfld", 32'h1_0438, 16'h0100);
    mchk("release", 32'h1_041C, 16'h0);
    rchk("desc", rbd_pkg::REG_CUR_DESC_ADDR, 32'h430);
    rchk("status", rbd_pkg::REG_STATUS, 32'h12);
    stop_test();
  end
endmodule
